// file: include/tc_capture_pkg.sv
// Purpose: Constants and state type for the capture-mode timer channel.
// Assumes: Classic Wishbone slave with 32-bit data, 16-bit counter.
// Notes: Register layout and control bits are local choices.
// How it works
// - A second capture load stops the counter clock only while the stop bit is set.
// - The trigger edge field decodes 0 as no trigger, 1 rising, 2 falling and 3 each edge.
// - The trigger line select bit picks line two when 0 and line one when 1.
// - Only with compare-C restart on does a third compare match clear and start the counter.
// - The waveform select bit gives capture mode when 0 and waveform mode when 1.
// - First capture loads on no edge, rising, falling or each edge of line one, per its field.
// - Second capture loads on no edge, rising, falling or each edge of line one, per its field.
// - The trigger acts only on the selected transition and is ignored when no edge is selected.
package tc_capture_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [4:0] MODE_OFS = 5'h00;
  localparam logic [4:0] CTRL_OFS = 5'h04;
  localparam logic [4:0] COUNT_OFS = 5'h08;
  localparam logic [4:0] FIRST_CAP_OFS = 5'h0c;
  localparam logic [4:0] SECOND_CAP_OFS = 5'h10;
  localparam logic [4:0] THIRD_CMP_OFS = 5'h14;
  localparam logic [4:0] STATUS_OFS = 5'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int WAVE_POS = 0;
  localparam int TRIG_EDGE_POS = 1;
  localparam int TRIG_LINE_POS = 3;
  localparam int RESTART_POS = 4;
  localparam int STOP_POS = 5;
  localparam int FIRST_EDGE_POS = 6;
  localparam int SECOND_EDGE_POS = 8;
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_DIS_POS = 1;
  localparam int MODE_W = 10;
  localparam int CNT_W = 16;
  // ****************************************
  // Edge codes and reset values
  // ****************************************
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [9:0] MODE_RESET = 10'h000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] THIRD_CMP_RESET = 16'hffff;
  // ****************************************
  // Module state
  // ****************************************
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [9:0] mode;
    logic clk_en;
    logic [15:0] cnt;
    logic [15:0] first_cap;
    logic [15:0] second_cap;
    logic [15:0] third_cmp;
    logic ack;
    logic [31:0] rdata;
  } state_t;
endpackage : tc_capture_pkg

// file: design/tc_capture.sv
// Purpose: Capture-mode configuration and counting of one timer channel.
// Assumes: Line inputs are asynchronous; registers reached over classic Wishbone.
// Notes: Register layout and control bits are local choices.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module tc_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer lines
  input wire logic timer_line_one_i,
  input wire logic timer_line_two_i,
  // Status
  output logic clock_running_o,
  output logic waveform_mode_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      tc_capture_pkg::EDGE_NONE: hit = 1'b0;
      tc_capture_pkg::EDGE_RISE: hit = rise;
      tc_capture_pkg::EDGE_FALL: hit = fall;
      tc_capture_pkg::EDGE_BOTH: hit = rise | fall;
    endcase
    return hit;
  endfunction : edge_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // ****************************************
  // State
  // ****************************************
  tc_capture_pkg::state_t state_reg;
  tc_capture_pkg::state_t state_next;

  logic wave;
  logic [1:0] trig_edge;
  logic trig_line;
  logic restart_en;
  logic stop_en;
  logic [1:0] first_edge;
  logic [1:0] second_edge;
  logic rise_one;
  logic fall_one;
  logic rise_two;
  logic fall_two;
  logic trig_rise;
  logic trig_fall;
  logic trig_hit;
  logic cmp_match;
  logic restart;
  logic first_load;
  logic second_load;
  logic bus_req;
  logic wr_now;
  logic sw_en;
  logic sw_dis;

  assign wave = state_reg.mode[tc_capture_pkg::WAVE_POS];
  assign trig_edge = state_reg.mode[tc_capture_pkg::TRIG_EDGE_POS +: 2];
  assign trig_line = state_reg.mode[tc_capture_pkg::TRIG_LINE_POS];
  assign restart_en = state_reg.mode[tc_capture_pkg::RESTART_POS];
  assign stop_en = state_reg.mode[tc_capture_pkg::STOP_POS];
  assign first_edge = state_reg.mode[tc_capture_pkg::FIRST_EDGE_POS +: 2];
  assign second_edge = state_reg.mode[tc_capture_pkg::SECOND_EDGE_POS +: 2];

  // ****************************************
  // Edge detection and events
  // ****************************************
  assign rise_one = state_reg.sync2[0] & ~state_reg.prev[0];
  assign fall_one = ~state_reg.sync2[0] & state_reg.prev[0];
  assign rise_two = state_reg.sync2[1] & ~state_reg.prev[1];
  assign fall_two = ~state_reg.sync2[1] & state_reg.prev[1];
  assign trig_rise = trig_line ? rise_one : rise_two;
  assign trig_fall = trig_line ? fall_one : fall_two;
  assign trig_hit = edge_hit(trig_edge, trig_rise, trig_fall);
  assign cmp_match = restart_en & state_reg.clk_en & (state_reg.cnt == state_reg.third_cmp);
  assign restart = trig_hit | cmp_match;
  assign first_load = ~wave & edge_hit(first_edge, rise_one, fall_one);
  assign second_load = ~wave & edge_hit(second_edge, rise_one, fall_one);

  // ****************************************
  // Bus decode
  // ****************************************
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_now = bus_req & wb_we_i & state_reg.ack;
  assign sw_en = wr_now & (wb_adr_i == tc_capture_pkg::CTRL_OFS) &
                 wb_sel_i[0] & wb_dat_i[tc_capture_pkg::CTRL_EN_POS];
  assign sw_dis = wr_now & (wb_adr_i == tc_capture_pkg::CTRL_OFS) &
                  wb_sel_i[0] & wb_dat_i[tc_capture_pkg::CTRL_DIS_POS];

  always_comb begin
    logic [31:0] tmp;
    tmp = 32'h0000_0000;
    state_next = state_reg;
    state_next.sync1 = {timer_line_two_i, timer_line_one_i};
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    // Counter clock control
    if (sw_en) begin
      state_next.clk_en = 1'b1;
    end
    if (second_load && stop_en) begin
      state_next.clk_en = 1'b0;
    end
    if (sw_dis) begin
      state_next.clk_en = 1'b0;
    end
    // Counting and restart
    if (restart) begin
      state_next.cnt = tc_capture_pkg::CNT_RESET;
      state_next.clk_en = 1'b1;
    end else if (state_reg.clk_en) begin
      state_next.cnt = state_reg.cnt + 16'h0001;
    end
    // Captures
    if (first_load) begin
      state_next.first_cap = state_reg.cnt;
    end
    if (second_load) begin
      state_next.second_cap = state_reg.cnt;
    end
    // Register writes
    if (wr_now && wb_adr_i == tc_capture_pkg::MODE_OFS) begin
      tmp = merge({22'h0, state_reg.mode}, wb_dat_i, wb_sel_i);
      state_next.mode = tmp[9:0];
    end
    if (wr_now && wb_adr_i == tc_capture_pkg::THIRD_CMP_OFS) begin
      tmp = merge({16'h0000, state_reg.third_cmp}, wb_dat_i, wb_sel_i);
      state_next.third_cmp = tmp[15:0];
    end
    // Answer and read data
    state_next.ack = bus_req & ~state_reg.ack;
    state_next.rdata = 32'h0000_0000;
    if (bus_req && !state_reg.ack && !wb_we_i) begin
      unique case (wb_adr_i)
        tc_capture_pkg::MODE_OFS: state_next.rdata = {22'h0, state_reg.mode};
        tc_capture_pkg::COUNT_OFS: state_next.rdata = {16'h0000, state_reg.cnt};
        tc_capture_pkg::FIRST_CAP_OFS: state_next.rdata = {16'h0000, state_reg.first_cap};
        tc_capture_pkg::SECOND_CAP_OFS: state_next.rdata = {16'h0000, state_reg.second_cap};
        tc_capture_pkg::THIRD_CMP_OFS: state_next.rdata = {16'h0000, state_reg.third_cmp};
        tc_capture_pkg::STATUS_OFS: state_next.rdata = {29'h0, state_reg.sync2,
                                                         state_reg.clk_en};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '{sync1: 2'h0, sync2: 2'h0, prev: 2'h0,
                     mode: tc_capture_pkg::MODE_RESET, clk_en: 1'b0,
                     cnt: tc_capture_pkg::CNT_RESET, first_cap: tc_capture_pkg::CNT_RESET,
                     second_cap: tc_capture_pkg::CNT_RESET,
                     third_cmp: tc_capture_pkg::THIRD_CMP_RESET,
                     ack: 1'b0, rdata: 32'h0000_0000};
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign clock_running_o = state_reg.clk_en;
  assign waveform_mode_o = wave;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************
  // Bus answer
  // ****************************************
  a_ack_answer: assert property (
    bus_req && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_ack_idle: assert property (
    !bus_req |=> !wb_ack_o)
    else $error("acknowledge without request");
  a_dat_quiet: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside acknowledge");
  a_read_mode: assert property (
    bus_req && !wb_ack_o && !wb_we_i && wb_adr_i == tc_capture_pkg::MODE_OFS |=>
    wb_dat_o == {22'h0, $past(state_reg.mode)}) else $error("mode read back wrong");
  a_unmapped_read: assert property (
    bus_req && !wb_ack_o && !wb_we_i && wb_adr_i > tc_capture_pkg::STATUS_OFS |=>
    wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_unmapped_write: assert property (
    wr_now && wb_adr_i > tc_capture_pkg::STATUS_OFS |=>
    $stable(state_reg.mode) && $stable(state_reg.third_cmp)) else $error("unmapped write landed");
  a_mode_write: assert property (
    wr_now && wb_adr_i == tc_capture_pkg::MODE_OFS && wb_sel_i == 4'hf |=>
    {22'h0, state_reg.mode} == ($past(wb_dat_i) & 32'h0000_03ff)) else $error("mode write lost");
  a_cmp_write: assert property (
    wr_now && wb_adr_i == tc_capture_pkg::THIRD_CMP_OFS && wb_sel_i == 4'hf |=>
    {16'h0, state_reg.third_cmp} == ($past(wb_dat_i) & 32'h0000_ffff))
    else $error("compare write lost");

  // ****************************************
  // Counter clock
  // ****************************************
  a_sw_enable: assert property (
    sw_en && !sw_dis && !(second_load && stop_en) |=> state_reg.clk_en)
    else $error("software enable ignored");
  a_sw_disable: assert property (
    sw_dis && !restart |=> !state_reg.clk_en)
    else $error("software disable ignored");
  a_stop_on_second: assert property (
    second_load && stop_en && !restart |=> !state_reg.clk_en)
    else $error("clock still running after second capture");
  a_keep_running: assert property (
    second_load && !stop_en && state_reg.clk_en && !sw_dis |=> state_reg.clk_en)
    else $error("clock stopped with stop bit clear");
  a_stop_wave: assert property (
    wave && state_reg.clk_en && !sw_dis |=> state_reg.clk_en)
    else $error("stop bit acted in waveform mode");
  a_count_step: assert property (
    state_reg.clk_en && !restart |=> state_reg.cnt == $past(state_reg.cnt) + 16'h0001)
    else $error("counter did not step");
  a_count_hold: assert property (
    !state_reg.clk_en && !restart |=> $stable(state_reg.cnt))
    else $error("counter moved while stopped");

  // ****************************************
  // Trigger and compare restart
  // ****************************************
  a_trig_none: assert property (
    trig_edge == tc_capture_pkg::EDGE_NONE && !cmp_match && state_reg.clk_en |=>
    state_reg.cnt == $past(state_reg.cnt) + 16'h0001) else $error("trigger with no edge");
  a_trig_line_one: assert property (
    trig_line && rise_one && trig_edge == tc_capture_pkg::EDGE_RISE |=>
    state_reg.cnt == 16'h0000 && state_reg.clk_en) else $error("line one rising trigger ignored");
  a_trig_line_two: assert property (
    !trig_line && fall_two && trig_edge == tc_capture_pkg::EDGE_FALL |=>
    state_reg.cnt == 16'h0000 && state_reg.clk_en) else $error("line two falling trigger ignored");
  a_trig_rise_only: assert property (
    trig_edge == tc_capture_pkg::EDGE_RISE && trig_fall && !state_reg.clk_en && !sw_en |=>
    !state_reg.clk_en) else $error("falling edge acted with rising selected");
  a_trig_fall_only: assert property (
    trig_edge == tc_capture_pkg::EDGE_FALL && trig_rise && !state_reg.clk_en && !sw_en |=>
    !state_reg.clk_en) else $error("rising edge acted with falling selected");
  a_trig_both: assert property (
    trig_edge == tc_capture_pkg::EDGE_BOTH && (trig_rise || trig_fall) |=>
    state_reg.cnt == 16'h0000 && state_reg.clk_en) else $error("either edge trigger ignored");
  a_trig_unselected: assert property (
    trig_line && (rise_two || fall_two) && !rise_one && !fall_one &&
    !state_reg.clk_en && !sw_en |=> !state_reg.clk_en) else $error("unselected line triggered");
  a_cmp_restart: assert property (
    cmp_match |=> state_reg.cnt == 16'h0000 && state_reg.clk_en)
    else $error("compare match did not restart counter");
  a_cmp_ignored: assert property (
    !restart_en && !trig_hit && state_reg.clk_en &&
    state_reg.cnt == state_reg.third_cmp |=> state_reg.cnt == $past(state_reg.cnt) + 16'h0001)
    else $error("compare match acted while disabled");

  // ****************************************
  // Captures
  // ****************************************
  a_wave_no_cap: assert property (
    wave |=> $stable(state_reg.first_cap) && $stable(state_reg.second_cap))
    else $error("capture in waveform mode");
  a_first_value: assert property (
    first_load |=> state_reg.first_cap == $past(state_reg.cnt))
    else $error("first capture value wrong");
  a_second_value: assert property (
    second_load |=> state_reg.second_cap == $past(state_reg.cnt))
    else $error("second capture value wrong");
  a_first_none: assert property (
    first_edge == tc_capture_pkg::EDGE_NONE |=> $stable(state_reg.first_cap))
    else $error("first capture loaded with no edge");
  a_second_none: assert property (
    second_edge == tc_capture_pkg::EDGE_NONE |=> $stable(state_reg.second_cap))
    else $error("second capture loaded with no edge");
  a_first_skip: assert property (
    first_edge == tc_capture_pkg::EDGE_RISE && fall_one |=> $stable(state_reg.first_cap))
    else $error("first capture loaded on wrong edge");
  a_second_fall: assert property (
    !wave && second_edge == tc_capture_pkg::EDGE_FALL && fall_one |=>
    state_reg.second_cap == $past(state_reg.cnt)) else $error("falling load missed");

  // ****************************************
  // Cover points
  // ****************************************
  c_first_cap: cover property (first_load);
  c_second_stop: cover property (second_load && stop_en);
  c_cmp_restart: cover property (cmp_match);
  c_trigger: cover property (trig_hit);
  c_wave_run: cover property (wave && state_reg.clk_en);
endmodule : tc_capture

// file: tb/timer_lines_model.sv
// Purpose: Far side model driving the two timer lines.
// Assumes: Lines are push-pull, driven at all times.
// Notes: Levels follow the request one clock later.
`timescale 1ns/1ps
module timer_lines_model (
  // Clock
  input wire logic clk_i,
  // Requested levels, bit 0 line one
  input wire logic [1:0] want_i,
  // Line levels
  output logic line_one_o,
  output logic line_two_o
);
  initial begin
    line_one_o = 1'b0;
    line_two_o = 1'b0;
  end
  always @(posedge clk_i) begin
    line_one_o <= want_i[0];
    line_two_o <= want_i[1];
  end
endmodule : timer_lines_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the capture-mode timer channel.
// Assumes: Bus always answers; only the cycle ceiling ends a wait.
// Notes: Random pulse gaps and compare values, seed fixed.
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, l1, l2, run, wave;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, q, a0, b0, a1, b1;
  logic [1:0] want = 2'h0;
  int n_mismatch = 0, n_tests = 0, ticks = 0, g, cmpv;
  always #12.5 clk_i = ~clk_i;
  timer_lines_model lines (.clk_i(clk_i), .want_i(want), .line_one_o(l1), .line_two_o(l2));
  tc_capture dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_line_one_i(l1), .timer_line_two_i(l2),
    .clock_running_o(run), .waveform_mode_o(wave));
  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic edge_hit(input logic [1:0] code, input logic rising);
    return rising ? code[0] : code[1];
  endfunction : edge_hit
  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic waitn(input int n);
    repeat (n) @(posedge clk_i);
  endtask : waitn
  task automatic caps(output logic [31:0] a, output logic [31:0] b);
    bus(1'b0, tc_capture_pkg::FIRST_CAP_OFS, 32'h0);
    a = q;
    bus(1'b0, tc_capture_pkg::SECOND_CAP_OFS, 32'h0);
    b = q;
  endtask : caps
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(66));
    waitn(5);
    rst_i <= 1'b0;
    bus(1'b0, tc_capture_pkg::MODE_OFS, 32'h0);
    check("mode", q, {22'h0, tc_capture_pkg::MODE_RESET});
    bus(1'b0, tc_capture_pkg::THIRD_CMP_OFS, 32'h0);
    check("cmp", q, {16'h0, tc_capture_pkg::THIRD_CMP_RESET});
    bus(1'b1, 5'h1c, 32'h3ff);
    bus(1'b0, 5'h1c, 32'h0);
    check("unmapped", q, 32'h0);
    $display("done reset");
    for (int e = 0; e < 4; e++) begin
      for (int s = 0; s < 2; s++) begin
        bus(1'b1, tc_capture_pkg::MODE_OFS, 32'((s << 3) | (e << 1)));
        bus(1'b1, tc_capture_pkg::CTRL_OFS, 32'h2);
        want <= (s == 1) ? 2'h2 : 2'h1;
        waitn(6);
        check("unselected", 32'(run), 32'h0);
        want <= (s == 1) ? 2'h1 : 2'h2;
        waitn(6);
        check("trig_rise", 32'(run), 32'(edge_hit(2'(e), 1'b1)));
        bus(1'b1, tc_capture_pkg::CTRL_OFS, 32'h2);
        want <= 2'h0;
        waitn(6);
        check("trig_fall", 32'(run), 32'(edge_hit(2'(e), 1'b0)));
      end
    end
    $display("done trigger");
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, tc_capture_pkg::MODE_OFS, 32'((c << 6) | (c << 8)));
      bus(1'b1, tc_capture_pkg::CTRL_OFS, 32'h1);
      caps(a0, b0);
      want <= 2'h1;
      waitn(6);
      caps(a1, b1);
      check("first_rise", 32'(a1 !== a0), 32'(edge_hit(2'(c), 1'b1)));
      check("second_rise", 32'(b1 !== b0), 32'(edge_hit(2'(c), 1'b1)));
      want <= 2'h0;
      waitn(6);
      caps(a0, b0);
      check("first_fall", 32'(a0 !== a1), 32'(edge_hit(2'(c), 1'b0)));
      check("second_fall", 32'(b0 !== b1), 32'(edge_hit(2'(c), 1'b0)));
    end
    $display("done capture");
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, tc_capture_pkg::MODE_OFS,
        32'h240 | ((k != 1) ? 32'h20 : 32'h0) | ((k == 2) ? 32'h1 : 32'h0));
      bus(1'b1, tc_capture_pkg::CTRL_OFS, 32'h1);
      caps(a0, b0);
      g = 4 + int'($urandom % 20);
      want <= 2'h1;
      waitn(g);
      want <= 2'h0;
      waitn(6);
      caps(a1, b1);
      if (k < 2) check("gap", b1 - a1, 32'(g));
      else check("hold", a1, a0);
      check("running", 32'(run), 32'(k != 0));
      check("wave", 32'(wave), 32'(k == 2));
      bus(1'b0, tc_capture_pkg::STATUS_OFS, 32'h0);
      check("status", q, 32'(k != 0));
    end
    $display("done stop");
    cmpv = 20 + int'($urandom % 40);
    bus(1'b1, tc_capture_pkg::THIRD_CMP_OFS, 32'(cmpv));
    bus(1'b1, tc_capture_pkg::MODE_OFS, 32'h1a);
    want <= 2'h1;
    waitn(6);
    want <= 2'h0;
    repeat (8) begin
      waitn(int'($urandom % 30));
      bus(1'b0, tc_capture_pkg::COUNT_OFS, 32'h0);
      check("restart", 32'(q <= 32'(cmpv)), 32'h1);
    end
    bus(1'b1, tc_capture_pkg::MODE_OFS, 32'h0);
    waitn(cmpv + 10);
    bus(1'b0, tc_capture_pkg::COUNT_OFS, 32'h0);
    check("no_restart", 32'(q > 32'(cmpv)), 32'h1);
    $display("done compare");
    tally_and_finish();
  end
endmodule : tb
